// File: rtl/dtc_timer.sv
// Purpose: Dual 8-bit timer with cascade, carrier and PWM modes, AHB-Lite slave
// Assumes: Single clock, zero-wait-state slave while ce is high
// Notes:   Port pins are split into in, out and output enable
// Functional notes
// - Timer A run low clears and halts A; high starts it unless cascaded.
// - Timer A clock: main/64, main/256, B match, or carrier/B output.
// - Mode bits 000 discrete, 101 cascade, 011 carrier, 010 PWM only.
// - Cascade ignores timer A run; both halves follow timer B run.
// - Cascade forces timer A clock from timer B overflow carry and the combined match.
// - Timer B run low clears B, and A when cascaded; high starts them.
// - Timer B clock: main /1, /4, /2, /4, /8, /16.
// - Output enable 0 leaves pin to port; 1 routes timer B output.
// - Carrier control is write-only, upper five bits zero, reset 00h.
// - With output data 1, remote bit picks carrier (0) or steady high (1).
// - Next output data copies into active output data on timer A match.
// - Carrier mode: active data 0 drives low, 1 emits carrier.
// - Direction bit 0 drives pin, 1 releases it; reset FFh, bits 2-7 read 1.
// - Both mode control registers reset to 00h: stopped, discrete, no output.
// - Discrete: counter/compare match raises that timer's interrupt, clears it.
// - Cascade: B interrupt only on both matching together; no A interrupt.
// - Carrier and PWM: high-width compare sets B output high duration.
// - Carrier mode: B carrier gated to output in periods set by A.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ns
module dtc_timer
	import dtc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Port 6 pins
	input  wire logic [1:0]  port6_pin_in,
	output logic      [1:0]  port6_pin_out,
	output logic      [1:0]  port6_pin_oe,
	// Timer events
	output logic             timer_a_irq,
	output logic             timer_b_irq
);

	// Registers
	dtc_tmc_a_t   timer_a_mode_control;
	dtc_tmc_b_t   timer_b_mode_control;
	dtc_tca_t     carrier_output_control;
	logic [1:0]   port6_direction;
	logic [1:0]   port6_latch;
	logic [7:0]   timer_a_compare;
	logic [7:0]   timer_b_compare;
	logic [7:0]   high_width_compare;
	logic [7:0]   prescale;
	logic         out_b;
	logic [1:0]   pin_s1;
	logic [1:0]   pin_s2;
	logic [1:0]   pin_s3;
	logic [1:0]   pin_val;
	dtc_bus_req_t req;
	logic         req_valid;

	// Bus decode
	wire          take      = hsel && hready && ce &&
				(htrans == DTC_HTRANS_NONSEQ || htrans == DTC_HTRANS_SEQ);
	wire [15:0]   take_idx  = haddr[DTC_IDX_LSB +: DTC_IDX_W];
	wire          wr_now    = req_valid && req.write && ce;
	wire [7:0]    wbyte     = hwdata[DTC_BYTE_W-1:0];
	wire          wr_tmc_a  = wr_now && req.idx == DTC_IDX_TMC_A;
	wire          wr_tmc_b  = wr_now && req.idx == DTC_IDX_TMC_B;
	wire          wr_tca    = wr_now && req.idx == DTC_IDX_TCA;
	wire          wr_dir    = wr_now && req.idx == DTC_IDX_PORT_DIR;
	wire          wr_latch  = wr_now && req.idx == DTC_IDX_PORT_LATCH;
	wire          wr_cmp_a  = wr_now && req.idx == DTC_IDX_CMP_A;
	wire          wr_cmp_b  = wr_now && req.idx == DTC_IDX_CMP_B;
	wire          wr_high_w = wr_now && req.idx == DTC_IDX_HIGH_W;

	// Mode decode
	wire dtc_mode_t mode = dtc_mode_t'({timer_a_mode_control.mode_sel_cascade_bit,
				timer_b_mode_control.mode_sel_high_bit,
				timer_b_mode_control.mode_sel_low_bit});
	wire          is_cascade = (mode == DTC_MODE_CASCADE);
	wire          is_carrier = (mode == DTC_MODE_CARRIER);
	wire          is_pwm_like = is_carrier || (mode == DTC_MODE_PWM);

	// Run control
	wire          b_run     = timer_b_mode_control.timer_b_run;
	wire          a_run_eff = is_cascade ? b_run
				: timer_a_mode_control.timer_a_run;

	// Prescaler taps
	function automatic logic tap(input logic [7:0] pre, input logic [7:0] mask);
		tap = &(pre | ~mask);
	endfunction

	wire [2:0]    b_sel = timer_b_mode_control.timer_b_clk_sel;
	wire [7:0]    b_mask =
		(b_sel == DTC_B_SEL_DIV4 || b_sel == DTC_B_SEL_DIV4B) ? DTC_MASK_DIV4 :
		(b_sel == DTC_B_SEL_DIV2)  ? DTC_MASK_DIV2 :
		(b_sel == DTC_B_SEL_DIV8)  ? DTC_MASK_DIV8 :
		(b_sel == DTC_B_SEL_DIV16) ? DTC_MASK_DIV16 : DTC_MASK_DIV1;
	wire          b_tick = b_run && tap(prescale, b_mask);

	// Timer B compare and output state
	logic [7:0]   cnt_a;
	logic [7:0]   cnt_b;
	logic         a_eq;
	logic         b_eq;
	wire          bh_eq      = (cnt_b == high_width_compare);
	wire          casc_hit   = a_eq && b_eq;
	wire          b_hit      = is_cascade ? casc_hit :
				is_pwm_like ? (out_b ? bh_eq : b_eq) : b_eq;
	wire          b_match    = b_tick && b_hit;
	wire          b_carry    = is_cascade && b_tick && !b_hit && cnt_b == DTC_CNT_MAX;
	wire          next_out_b = is_pwm_like ? (b_match ? !out_b : out_b)
				: (out_b ^ b_match);
	wire          b_out_rise = next_out_b && !out_b;

	// Timer A count clock
	wire [1:0]    a_sel  = timer_a_mode_control.timer_a_clk_sel;
	wire          a_src  =
		(a_sel == DTC_A_SEL_DIV64)  ? tap(prescale, DTC_MASK_DIV64) :
		(a_sel == DTC_A_SEL_DIV256) ? tap(prescale, DTC_MASK_DIV256) :
		(a_sel == DTC_A_SEL_BMATCH) ? b_match : b_out_rise;
	wire          a_tick = a_run_eff &&
				(is_cascade ? (b_carry || b_match) : a_src);
	wire          a_hit  = is_cascade ? b_match : a_eq;
	wire          a_match = !is_cascade && a_tick && a_eq;

	dtc_counter u_cnt_a (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.clear (!a_run_eff),
		.tick  (a_tick),
		.hit   (a_hit),
		.cmp   (timer_a_compare),
		.count (cnt_a),
		.equal (a_eq)
	);

	dtc_counter u_cnt_b (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.clear (!b_run),
		.tick  (b_tick),
		.hit   (b_hit),
		.cmp   (timer_b_compare),
		.count (cnt_b),
		.equal (b_eq)
	);

	// Output path
	wire          active   = carrier_output_control.active_output_data;
	wire          timer_out = is_carrier ?
				(active && (carrier_output_control.remote_level_select || out_b))
				: out_b;
	wire          toe      = timer_b_mode_control.timer_out_enable;
	wire [1:0]    next_pin = {port6_latch[1], toe ? timer_out : port6_latch[0]};

	assign port6_pin_oe = ~port6_direction;
	assign hreadyout    = ce;
	assign hresp        = DTC_HRESP_OKAY;

	// Read mux
	wire [7:0]    rd_port = {DTC_DIR_FILL, port6_direction};
	wire [7:0]    rd_lat  = {DTC_DIR_FILL & 6'h00,
				(port6_direction & pin_val) | (~port6_direction & port6_latch)};
	wire [7:0]    rd_byte =
		(take_idx == DTC_IDX_TMC_A)      ? timer_a_mode_control :
		(take_idx == DTC_IDX_TMC_B)      ? timer_b_mode_control :
		(take_idx == DTC_IDX_PORT_DIR)   ? rd_port :
		(take_idx == DTC_IDX_PORT_LATCH) ? rd_lat :
		(take_idx == DTC_IDX_CMP_A)      ? timer_a_compare :
		(take_idx == DTC_IDX_CMP_B)      ? timer_b_compare :
		(take_idx == DTC_IDX_HIGH_W)     ? high_width_compare :
		(take_idx == DTC_IDX_CNT_A)      ? cnt_a :
		(take_idx == DTC_IDX_CNT_B)      ? cnt_b : DTC_CNT_ZERO;

	// Bus phase tracking
	always_ff @(posedge clk) begin
		if (rst) begin
			req_valid <= 1'b0;
			req       <= '0;
			hrdata    <= '0;
		end else if (ce) begin
			req_valid <= take;
			req       <= '{idx: take_idx, write: hwrite};
			if (take && !hwrite) begin
				hrdata <= {{(DTC_DATA_W - DTC_BYTE_W){1'b0}}, rd_byte};
			end
		end
	end

	// Mode control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_a_mode_control <= DTC_RST_TMC;
			timer_b_mode_control <= DTC_RST_TMC;
		end else if (ce) begin
			if (wr_tmc_a) begin
				timer_a_mode_control      <= wbyte;
				timer_a_mode_control.rsv6 <= '0;
				timer_a_mode_control.rsv2 <= 1'b0;
				timer_a_mode_control.rsv0 <= 1'b0;
			end
			if (wr_tmc_b) begin
				timer_b_mode_control      <= wbyte;
				timer_b_mode_control.rsv6 <= 1'b0;
			end
		end
	end

	// Carrier output control, hardware copy wins over a write
	always_ff @(posedge clk) begin
		if (rst) begin
			carrier_output_control <= DTC_RST_TCA;
		end else if (ce) begin
			if (wr_tca) begin
				carrier_output_control     <= wbyte;
				carrier_output_control.rsv <= '0;
			end
			if (a_match) begin
				carrier_output_control.active_output_data <=
					wr_tca ? wbyte[1] : carrier_output_control.next_output_data;
			end
		end
	end

	// Compare, port and prescaler state
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_a_compare    <= DTC_RST_CMP;
			timer_b_compare    <= DTC_RST_CMP;
			high_width_compare <= DTC_RST_CMP;
			port6_direction    <= DTC_RST_DIR;
			port6_latch        <= DTC_RST_LATCH;
			prescale           <= DTC_CNT_ZERO;
			out_b              <= 1'b0;
			port6_pin_out      <= DTC_RST_LATCH;
			timer_a_irq        <= 1'b0;
			timer_b_irq        <= 1'b0;
		end else if (ce) begin
			if (wr_cmp_a) timer_a_compare <= wbyte;
			if (wr_cmp_b) timer_b_compare <= wbyte;
			if (wr_high_w) high_width_compare <= wbyte;
			if (wr_dir) port6_direction <= wbyte[1:0];
			if (wr_latch) port6_latch <= wbyte[1:0];
			prescale      <= prescale + 8'h01;
			out_b         <= b_run ? next_out_b : 1'b0;
			port6_pin_out <= next_pin;
			timer_a_irq   <= a_match;
			timer_b_irq   <= b_match;
		end
	end

	// Pin input synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1  <= '0;
			pin_s2  <= '0;
			pin_s3  <= '0;
			pin_val <= '0;
		end else if (ce) begin
			pin_s1 <= port6_pin_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int i = 0; i < 2; i++) begin
				if (pin_s2[i] == pin_s3[i]) pin_val[i] <= pin_s3[i];
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_a_stop_clears;
		ce && !a_run_eff |=> cnt_a == DTC_CNT_ZERO;
	endproperty
	a_a_stop_clears: assert property (p_a_stop_clears)
		else $error("timer A not cleared while stopped");

	property p_cascade_ignores_a;
		ce && is_cascade && !b_run && timer_a_mode_control.timer_a_run
			|=> cnt_a == DTC_CNT_ZERO && cnt_b == DTC_CNT_ZERO;
	endproperty
	a_cascade_ignores_a: assert property (p_cascade_ignores_a)
		else $error("cascade counters run without timer B run");

	property p_bmatch_clock;
		ce && a_run_eff && !is_cascade && a_sel == DTC_A_SEL_BMATCH && !b_match
			|=> cnt_a == $past(cnt_a);
	endproperty
	a_bmatch_clock: assert property (p_bmatch_clock)
		else $error("timer A counted without a timer B match");

	property p_discrete_match;
		ce && mode == DTC_MODE_DISCRETE && a_tick && a_eq
			|=> timer_a_irq && cnt_a == DTC_CNT_ZERO;
	endproperty
	a_discrete_match: assert property (p_discrete_match)
		else $error("discrete match did not interrupt and clear");

	property p_cascade_no_a_irq;
		is_cascade [*2] |-> !timer_a_irq;
	endproperty
	a_cascade_no_a_irq: assert property (p_cascade_no_a_irq)
		else $error("timer A interrupt raised in cascade");

	sequence s_copy_event;
		ce && a_match && !wr_tca;
	endsequence
	property p_copy_next;
		logic nxt;
		(s_copy_event, nxt = carrier_output_control.next_output_data)
			|=> carrier_output_control.active_output_data == nxt;
	endproperty
	a_copy_next: assert property (p_copy_next)
		else $error("next output data not copied on timer A match");

	property p_carrier_low;
		ce && is_carrier && toe && !active && !a_match && !wr_now ##1 ce |=> !port6_pin_out[0];
	endproperty
	a_carrier_low: assert property (p_carrier_low)
		else $error("pin not low with carrier stopped");

	property p_port_mode;
		ce && !toe |=> port6_pin_out[0] == $past(port6_latch[0]);
	endproperty
	a_port_mode: assert property (p_port_mode)
		else $error("pin left port control with output disabled");

	property p_pwm_fall;
		ce && is_pwm_like && out_b && b_tick && bh_eq
			|=> !out_b && cnt_b == DTC_CNT_ZERO;
	endproperty
	a_pwm_fall: assert property (p_pwm_fall)
		else $error("high width match did not drop the output");

	property p_reset_vals;
		$fell(rst) |-> timer_a_mode_control == DTC_RST_TMC
			&& timer_b_mode_control == DTC_RST_TMC
			&& port6_direction == DTC_RST_DIR && carrier_output_control == DTC_RST_TCA;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("registers wrong after reset");

endmodule

// File: rtl/dtc_pkg.sv
// Purpose: Shared constants and types for the dual 8-bit timer block
// Assumes: 100 MHz main clock, registers reached over AHB-Lite
// Notes:   Register offsets are word indices; the byte address is index * 4
package dtc_pkg;

	// Bus geometry
	localparam int unsigned DTC_ADDR_W  = 18;
	localparam int unsigned DTC_IDX_W   = 16;
	localparam int unsigned DTC_BYTE_W  = 8;
	localparam int unsigned DTC_DATA_W  = 32;
	localparam int unsigned DTC_IDX_LSB = 2;

	// Register word indices
	localparam logic [15:0] DTC_IDX_PORT_DIR   = 16'hff26;
	localparam logic [15:0] DTC_IDX_PORT_LATCH = 16'hff06;
	localparam logic [15:0] DTC_IDX_CMP_A      = 16'hff62;
	localparam logic [15:0] DTC_IDX_CNT_A      = 16'hff63;
	localparam logic [15:0] DTC_IDX_TMC_A      = 16'hff65;
	localparam logic [15:0] DTC_IDX_CMP_B      = 16'hff66;
	localparam logic [15:0] DTC_IDX_HIGH_W     = 16'hff67;
	localparam logic [15:0] DTC_IDX_CNT_B      = 16'hff68;
	localparam logic [15:0] DTC_IDX_TMC_B      = 16'hff69;
	localparam logic [15:0] DTC_IDX_TCA        = 16'hff6a;

	// Reset values
	localparam logic [7:0] DTC_RST_TMC   = 8'h00;
	localparam logic [7:0] DTC_RST_TCA   = 8'h00;
	localparam logic [7:0] DTC_RST_CMP   = 8'h00;
	localparam logic [1:0] DTC_RST_DIR   = 2'h3;
	localparam logic [1:0] DTC_RST_LATCH = 2'h0;
	localparam logic [5:0] DTC_DIR_FILL  = 6'h3f;
	localparam logic [7:0] DTC_CNT_ZERO  = 8'h00;
	localparam logic [7:0] DTC_CNT_MAX   = 8'hff;

	// Prescaler tap masks (tick when all masked bits are one)
	localparam logic [7:0] DTC_MASK_DIV1   = 8'h00;
	localparam logic [7:0] DTC_MASK_DIV2   = 8'h01;
	localparam logic [7:0] DTC_MASK_DIV4   = 8'h03;
	localparam logic [7:0] DTC_MASK_DIV8   = 8'h07;
	localparam logic [7:0] DTC_MASK_DIV16  = 8'h0f;
	localparam logic [7:0] DTC_MASK_DIV64  = 8'h3f;
	localparam logic [7:0] DTC_MASK_DIV256 = 8'hff;

	// Count clock select codes
	localparam logic [1:0] DTC_A_SEL_DIV64  = 2'h0;
	localparam logic [1:0] DTC_A_SEL_DIV256 = 2'h1;
	localparam logic [1:0] DTC_A_SEL_BMATCH = 2'h2;
	localparam logic [2:0] DTC_B_SEL_DIV1   = 3'h0;
	localparam logic [2:0] DTC_B_SEL_DIV4   = 3'h1;
	localparam logic [2:0] DTC_B_SEL_DIV2   = 3'h2;
	localparam logic [2:0] DTC_B_SEL_DIV4B  = 3'h3;
	localparam logic [2:0] DTC_B_SEL_DIV8   = 3'h4;
	localparam logic [2:0] DTC_B_SEL_DIV16  = 3'h5;

	// AHB-Lite codes
	localparam logic [1:0] DTC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] DTC_HTRANS_SEQ    = 2'h3;
	localparam logic       DTC_HRESP_OKAY    = 1'b0;

	typedef enum logic [2:0] {
		DTC_MODE_DISCRETE = 3'b000,
		DTC_MODE_PWM      = 3'b010,
		DTC_MODE_CARRIER  = 3'b011,
		DTC_MODE_CASCADE  = 3'b101
	} dtc_mode_t;

	typedef struct packed {
		logic       timer_a_run;
		logic [1:0] rsv6;
		logic [1:0] timer_a_clk_sel;
		logic       rsv2;
		logic       mode_sel_cascade_bit;
		logic       rsv0;
	} dtc_tmc_a_t;

	typedef struct packed {
		logic       timer_b_run;
		logic       rsv6;
		logic [2:0] timer_b_clk_sel;
		logic       mode_sel_high_bit;
		logic       mode_sel_low_bit;
		logic       timer_out_enable;
	} dtc_tmc_b_t;

	typedef struct packed {
		logic [4:0] rsv;
		logic       remote_level_select;
		logic       next_output_data;
		logic       active_output_data;
	} dtc_tca_t;

	typedef struct packed {
		logic [15:0] idx;
		logic        write;
	} dtc_bus_req_t;

endpackage

// File: rtl/dtc_counter.sv
// Purpose: One 8-bit up counter with compare, cleared on hit or stop
// Assumes: tick and hit come from the same clock domain
// Notes:   Overflow wraps to zero on its own
`timescale 1ns/1ns
module dtc_counter
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Control
	input  wire logic       clear,
	input  wire logic       tick,
	input  wire logic       hit,
	// Compare
	input  wire logic [7:0] cmp,
	output logic      [7:0] count,
	output logic            equal
);

	assign equal = (count == cmp);

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= DTC_CNT_ZERO;
		end else if (ce) begin
			if (clear || (tick && hit)) begin
				count <= DTC_CNT_ZERO;
			end else if (tick) begin
				count <= count + 8'h01;
			end
		end
	end

endmodule

// File: testbench/dtc_load.sv
// Purpose: External load on the two port 6 pins
// Assumes: No pull resistor on either pin
// Notes:   A released pin shows a level that flips every cycle
`timescale 1ns/1ns
module dtc_load (
	// Clock
	input  wire logic       clk,
	// Drive from the block
	input  wire logic [1:0] drv,
	input  wire logic [1:0] oe,
	// Levels seen on the pins
	output logic      [1:0] lvl
);
	logic [1:0] noise = 2'h1;

	always @(posedge clk) begin
		noise <= ~noise;
	end

	// Undriven pin floats, never holds the last value
	assign lvl = (drv & oe) | (noise & ~oe);
endmodule

// File: testbench/dual_timer_carrier_pwm_bench.sv
// Purpose: Self-checking bench for the dual timer block
// Assumes: Single bus master, ce high except in the freeze check, word transfers only
// Notes:   Periods are measured between successive rising events, widths between edges
`timescale 1ns/1ns
module dual_timer_carrier_pwm_bench
	import dtc_pkg::*;
();
	logic        clk;
	logic        rst;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [1:0]  pin_in;
	logic [1:0]  port6_pin_out;
	logic [1:0]  port6_pin_oe;
	logic        timer_a_irq;
	logic        timer_b_irq;
	int          fails;
	int          n_compared;
	int          a_cnt;
	int          c;
	int          h;
	logic [31:0] rd;
	logic [7:0]  v;
	logic [7:0]  w;
	int          dv[6] = '{1, 4, 2, 4, 8, 16};

	dtc_timer dtc_timer_i (
		.clk(clk), .rst(rst), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.port6_pin_in(pin_in), .port6_pin_out(port6_pin_out),
		.port6_pin_oe(port6_pin_oe),
		.timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq)
	);

	dtc_load dtc_load_i (.clk(clk), .drv(port6_pin_out), .oe(port6_pin_oe), .lvl(pin_in));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (timer_a_irq === 1'b1)
			a_cnt++;
	end

	task results;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Bounded wait for the slave's ready
	task wrdy;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1) begin
			fails++;
			$display("[FAIL] %0t ready timeout got %h exp %h", $time, hreadyout, 1'b1);
			results();
		end
	endtask

	task bus(input logic is_wr, input logic [15:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= DTC_HTRANS_NONSEQ;
		hwrite <= is_wr;
		haddr <= {14'h0, idx, 2'b00};
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wrdy();
		rd = hrdata;
	endtask

	task wr(input logic [15:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task rdchk(input logic [15:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rd, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// Timer B match interval per clock select code
	function int exp_b(int sel, int cmp);
		return (cmp + 1) * dv[sel];
	endfunction

	// Timer A match interval per clock select code, timer B at full rate
	function int exp_a(int sel, int cmp, int bcmp);
		int unit;
		unit = (sel == 0) ? 64 : (sel == 1) ? 256 : (sel == 2) ? (bcmp + 1) : 2 * (bcmp + 1);
		return (cmp + 1) * unit;
	endfunction

	function logic sigv(int s);
		case (s)
			0: return timer_a_irq;
			1: return timer_b_irq;
			default: return port6_pin_out[0];
		endcase
	endfunction

	// Cycles until signal s changes to val
	task ev(input int s, input logic val, output int n);
		logic p;
		logic q;
		n = 0;
		p = sigv(s);
		do begin
			@(posedge clk);
			#1;
			q = sigv(s);
			n++;
			if (p !== val && q === val)
				break;
			p = q;
		end while (n < 9000);
		if (n >= 9000) begin
			fails++;
			$display("[FAIL] %0t event timeout got %h exp %h", $time, n, 9000);
			results();
		end
	endtask

	task gap(input int s, output int n);
		ev(s, 1'b1, n);
		ev(s, 1'b1, n);
	endtask

	task hold(input logic val);
		logic ok;
		ok = 1'b1;
		repeat (100) begin
			@(posedge clk);
			#1;
			if (port6_pin_out[0] !== val)
				ok = 1'b0;
		end
		chk({31'h0, ok}, 32'h1);
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		void'($urandom(32'he48cc222));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(DTC_IDX_PORT_DIR, 32'hff);
		chk({30'h0, port6_pin_oe}, 32'h0);
		rdchk(DTC_IDX_TMC_A, 32'h0);
		rdchk(DTC_IDX_TMC_B, 32'h0);
		rdchk(DTC_IDX_TCA, 32'h0);
		wr(DTC_IDX_TCA, 8'hff);
		rdchk(DTC_IDX_TCA, 32'h0);
		wr(16'h1234, 8'h5a);
		rdchk(16'h1234, 32'h0);
		v = 8'($urandom);
		wr(DTC_IDX_PORT_DIR, v);
		rdchk(DTC_IDX_PORT_DIR, {24'h0, 6'h3f, v[1:0]});
		chk({30'h0, port6_pin_oe}, {30'h0, ~v[1:0]});
		// Timer B clock codes in discrete mode
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom_range(15, 1));
			wr(DTC_IDX_CMP_B, v);
			wr(DTC_IDX_TMC_B, {2'b10, 3'(i), 3'b000});
			gap(1, c);
			chk(c, exp_b(i, v));
			wr(DTC_IDX_TMC_B, 8'h00);
		end
		// Timer A clock codes, B running as a clock source
		w = 8'($urandom_range(7, 1));
		wr(DTC_IDX_CMP_B, w);
		wr(DTC_IDX_TMC_B, 8'h80);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom_range(3, 1));
			wr(DTC_IDX_CMP_A, v);
			wr(DTC_IDX_TMC_A, {3'b100, 2'(i), 3'b000});
			gap(0, c);
			chk(c, exp_a(i, v, w));
			wr(DTC_IDX_TMC_A, 8'h00);
		end
		repeat (3) @(posedge clk);
		rdchk(DTC_IDX_CNT_A, 32'h0);
		// Cascade with timer A run low and divide-by-256 selected
		wr(DTC_IDX_TMC_B, 8'h00);
		wr(DTC_IDX_CMP_A, 8'h02);
		v = 8'($urandom_range(15, 1));
		wr(DTC_IDX_CMP_B, v);
		wr(DTC_IDX_TMC_A, 8'h0a);
		a_cnt = 0;
		wr(DTC_IDX_TMC_B, 8'h82);
		gap(1, c);
		chk(c, 512 + v + 1);
		chk(a_cnt, 0);
		repeat (300) @(posedge clk);
		// Clock enable low freezes the 16-bit count at 300
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		chk({31'h0, hreadyout}, 32'h0);
		ce <= 1'b1;
		rdchk(DTC_IDX_CNT_B, 32'h2c);
		rdchk(DTC_IDX_CNT_A, 32'h1);
		wr(DTC_IDX_TMC_B, 8'h02);
		repeat (3) @(posedge clk);
		rdchk(DTC_IDX_CNT_A, 32'h0);
		rdchk(DTC_IDX_CNT_B, 32'h0);
		// Output disabled: pin follows the port latch
		wr(DTC_IDX_TMC_A, 8'h00);
		wr(DTC_IDX_TMC_B, 8'h80);
		wr(DTC_IDX_PORT_DIR, 8'hfe);
		wr(DTC_IDX_PORT_LATCH, 8'h01);
		hold(1'b1);
		chk({30'h0, port6_pin_out}, 32'h1);
		rdchk(DTC_IDX_PORT_LATCH, 32'h1);
		wr(DTC_IDX_PORT_LATCH, 8'h00);
		hold(1'b0);
		// Carrier generator
		wr(DTC_IDX_HIGH_W, 8'h02);
		wr(DTC_IDX_CMP_B, 8'h03);
		wr(DTC_IDX_CMP_A, 8'h01);
		wr(DTC_IDX_TMC_A, 8'h80);
		wr(DTC_IDX_TCA, 8'h00);
		wr(DTC_IDX_TMC_B, 8'h87);
		hold(1'b0);
		wr(DTC_IDX_TCA, 8'h07);
		hold(1'b1);
		wr(DTC_IDX_TCA, 8'h03);
		ev(2, 1'b1, c);
		ev(2, 1'b0, c);
		chk(c, 3);
		wr(DTC_IDX_TCA, 8'h06);
		ev(2, 1'b1, c);
		chk({31'h0, c <= 140}, 32'h1);
		hold(1'b1);
		// PWM with random widths
		wr(DTC_IDX_TMC_B, 8'h00);
		v = 8'($urandom_range(7, 1));
		w = 8'($urandom_range(7, 1));
		wr(DTC_IDX_HIGH_W, v);
		wr(DTC_IDX_CMP_B, w);
		wr(DTC_IDX_TMC_B, 8'h85);
		ev(2, 1'b1, c);
		ev(2, 1'b0, h);
		chk(h, v + 1);
		ev(2, 1'b1, h);
		chk(h, w + 1);
		results();
	end
endmodule
